// file: rtl/bri_pkg.sv
package bri_pkg;
   // Instruction and program counter geometry
   localparam int WORD_W = 10;
   localparam int PCL_W = 7;
   localparam int PAGE_W = 6;
   localparam int PC_W = 13;
   localparam int PAGE_MAX_DEF = 63;
   localparam int PAGE_MAX_SMALL = 31;

   // Opcode prefixes for the forms that carry fields
   localparam logic [2:0] OP_BIN = 3'h3;
   localparam logic [2:0] OP_CALL2 = 3'h2;
   localparam logic [4:0] OP_BLONG = 5'h07;
   localparam logic [4:0] OP_CLONG = 5'h06;
   localparam int W2_MARK = 9;

   // Exact opcodes
   localparam logic [9:0] OP_BIND = 10'h010;
   localparam logic [9:0] OP_CIND = 10'h030;
   localparam logic [9:0] OP_RTI = 10'h046;
   localparam logic [9:0] OP_RT = 10'h044;
   localparam logic [9:0] OP_RTS = 10'h045;
   localparam logic [9:0] OP_DIS = 10'h004;
   localparam logic [9:0] OP_ENA = 10'h005;
   localparam logic [9:0] OP_SKF = 10'h038;
   localparam logic [9:0] OP_SKP = 10'h03A;
   localparam logic [9:0] OP_RD1 = 10'h054;
   localparam logic [9:0] OP_WR1 = 10'h03F;
   localparam logic [9:0] OP_RD2 = 10'h055;
   localparam logic [9:0] OP_WR2 = 10'h03E;
   localparam logic [9:0] OP_RDP = 10'h253;
   localparam logic [9:0] OP_WRP = 10'h217;

   // Fixed page of the short call
   localparam logic [5:0] PAGE_CALL2 = 6'h02;

   // Control register bit positions
   localparam int V1_TEST_DIS = 0;
   localparam int I1_POL = 2;

   // Register port map
   localparam logic [1:0] OFS_STS = 2'h0;
   localparam logic [1:0] OFS_MSK = 2'h1;
   localparam logic [1:0] OFS_VREG = 2'h2;
   localparam logic [1:0] OFS_CORE = 2'h3;
   localparam int ST_EXT0 = 0;
   localparam int ST_PAGE = 1;
   localparam int ST_W = 2;

   // Reset values
   localparam logic [3:0] RST_CTRL = 4'h0;
   localparam logic RST_IEN = 1'b0;
   localparam logic [1:0] RST_MSK = 2'h0;

   typedef enum logic {BRI_FIRST, BRI_SECOND} bri_fetch_t;
   typedef enum logic [1:0] {BRI_BL, BRI_BLA, BRI_BML, BRI_BMLA} bri_long_t;

   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] word;
   } bri_instr_t;

   typedef struct packed {
      logic load;
      logic push;
      logic pop;
      logic restore;
      logic [PC_W-1:0] target;
   } bri_flow_t;
endpackage

// file: rtl/bri_exec.sv
// Overview of operation
// RQ1: In-page branch loads low PC bits, page unchanged.
// RQ2: Long branch jumps to address a in page from page field.
// RQ3: Page field allowed up to 31 or 63 depending on variant.
// RQ4: Indirect branch target is D low bits over accumulator, in page p.
// RQ5: Short call saves return point, jumps into page 2.
// RQ6: Long call saves return point, jumps to address in page p.
// RQ7: Indirect call saves return point, jumps to D and A address.
// RQ8: Interrupt return pops and restores saved core context.
// RQ9: Return resumes caller; skipping return also skips next word.
// RQ10: Disable instruction clears global interrupt enable.
// RQ11: Enable instruction sets global interrupt enable.
// RQ12: Flag test, test enabled: skip and clear flag if set.
// RQ13: Flag test, test disabled: pure no-operation.
// RQ14: Pin test, polarity one: skip when pin high.
// RQ15: Pin test, polarity zero: skip when pin low.
// RQ16: Copy first control register to and from accumulator.
// RQ17: Copy second control register to and from accumulator.
// RQ18: Copy pin control register to and from accumulator.
// RQ19: One word, one cycle each; skip voids the next instruction. Code voids one word, so a skipped two-word form's second word runs.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module bri_exec
   import bri_pkg::*;
#(
   parameter int PAGE_MAX = PAGE_MAX_DEF
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire bri_instr_t instr,
   input wire logic [PAGE_W-1:0] pc_page,
   input wire logic [3:0] acc,
   input wire logic [2:0] d_reg_low_bits,
   input wire logic int_pin,
   input wire logic ext0_req,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output bri_flow_t flow_q,
   output logic skip_q,
   output logic acc_load_q,
   output logic [3:0] acc_data_q,
   output logic global_irq_enable_flag_q,
   output logic ext0_request_flag_q,
   output logic [3:0] irq_ctrl_reg_one_q,
   output logic [3:0] irq_ctrl_reg_two_q,
   output logic [3:0] pin_irq_ctrl_reg_q,
   output logic [7:0] reg_rdata_q,
   output logic irq_q
);

   // Only the two memory sizes are served; refused while elaborating
   if (PAGE_MAX != PAGE_MAX_SMALL && PAGE_MAX != PAGE_MAX_DEF) begin : g_bad_page_max
      $error("PAGE_MAX must be 31 or 63");
   end

   bri_fetch_t fetch_q;
   bri_long_t long_q;
   logic [4:0] lo_page_q;
   logic [ST_W-1:0] sts_q;
   logic [ST_W-1:0] msk_q;
   logic [WORD_W-1:0] w;
   logic take;
   logic first;
   logic second;
   logic [6:0] long_page;
   logic page_ok;
   logic [PCL_W-1:0] ind_addr;
   logic skf_hit;
   logic [ST_W-1:0] sts_set;
   logic [ST_W-1:0] sts_clr;

   assign w = instr.word;
   // Word accepted this enabled cycle
   assign take = clk_en && instr.valid;
   // Skipped words are consumed but have no effect [RQ19]
   assign first = take && fetch_q == BRI_FIRST && !skip_q;
   assign second = take && fetch_q == BRI_SECOND;
   assign ind_addr = {d_reg_low_bits, acc}; // [RQ4] [RQ7]

   // Page of the second word, seven bits before the range check
   always_comb begin
      case (long_q)
         BRI_BL, BRI_BML: long_page = {w[8:7], lo_page_q};
         BRI_BLA, BRI_BMLA: long_page = {w[8:6], w[3:0]};
         default: long_page = 7'h00;
      endcase
   end
   // Pages past the variant's last one transfer nothing [RQ3]
   assign page_ok = w[W2_MARK] && long_page <= 7'(PAGE_MAX);

   // Two-word fetch sequencing
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fetch_q <= BRI_FIRST;
         long_q <= BRI_BL;
         lo_page_q <= 5'h00;
      end else if (clk_en) begin
         if (second) begin
            fetch_q <= BRI_FIRST;
         end else if (first) begin
            if (w[9:5] == OP_BLONG) begin
               fetch_q <= BRI_SECOND;
               long_q <= BRI_BL;
               lo_page_q <= w[4:0];
            end else if (w[9:5] == OP_CLONG) begin
               fetch_q <= BRI_SECOND;
               long_q <= BRI_BML;
               lo_page_q <= w[4:0];
            end else if (w == OP_BIND) begin
               fetch_q <= BRI_SECOND;
               long_q <= BRI_BLA;
            end else if (w == OP_CIND) begin
               fetch_q <= BRI_SECOND;
               long_q <= BRI_BMLA;
            end
         end
      end
   end

   // Program flow requests, at most one pulse per executed word
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         flow_q <= '0;
      end else if (clk_en) begin
         flow_q <= '0;
         if (second && page_ok) begin
            flow_q.load <= 1'b1;
            flow_q.push <= long_q == BRI_BML || long_q == BRI_BMLA; // [RQ6] [RQ7]
            if (long_q == BRI_BLA || long_q == BRI_BMLA) begin
               flow_q.target <= {long_page[5:0], ind_addr}; // [RQ4] [RQ7]
            end else begin
               flow_q.target <= {long_page[5:0], w[6:0]}; // [RQ2] [RQ6]
            end
         end else if (first) begin
            if (w[9:7] == OP_BIN) begin
               flow_q.load <= 1'b1;
               flow_q.target <= {pc_page, w[6:0]}; // [RQ1]
            end else if (w[9:7] == OP_CALL2) begin
               flow_q.load <= 1'b1;
               flow_q.push <= 1'b1;
               flow_q.target <= {PAGE_CALL2, w[6:0]}; // [RQ5]
            end else if (w == OP_RT || w == OP_RTS) begin
               flow_q.pop <= 1'b1; // [RQ9]
            end else if (w == OP_RTI) begin
               flow_q.pop <= 1'b1; // [RQ8]
               flow_q.restore <= 1'b1; // [RQ8]
            end
         end
      end
   end

   // Flag test hits only while the test is enabled [RQ12] [RQ13]
   assign skf_hit = first && w == OP_SKF && !irq_ctrl_reg_one_q[V1_TEST_DIS] && ext0_request_flag_q;

   // Skip state; a skip lasts exactly one taken word [RQ19]
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         skip_q <= 1'b0;
      end else if (clk_en) begin
         if (take && skip_q) begin
            skip_q <= 1'b0; // [RQ19]
         end else if (first) begin
            if (w == OP_RTS) begin
               skip_q <= 1'b1; // [RQ9]
            end else if (w == OP_SKF) begin
               skip_q <= skf_hit; // [RQ12] [RQ13]
            end else if (w == OP_SKP) begin
               skip_q <= int_pin == pin_irq_ctrl_reg_q[I1_POL]; // [RQ14] [RQ15]
            end
         end
      end
   end

   // Global interrupt enable
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         global_irq_enable_flag_q <= RST_IEN;
      end else if (clk_en && first) begin
         if (w == OP_DIS) begin
            global_irq_enable_flag_q <= 1'b0; // [RQ10]
         end else if (w == OP_ENA) begin
            global_irq_enable_flag_q <= 1'b1; // [RQ11]
         end
      end
   end

   // External request flag; a new request beats the test's clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext0_request_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (ext0_req) begin
            ext0_request_flag_q <= 1'b1;
         end else if (skf_hit) begin
            ext0_request_flag_q <= 1'b0; // [RQ12]
         end
      end
   end

   // Control registers written from the accumulator
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_ctrl_reg_one_q <= RST_CTRL;
         irq_ctrl_reg_two_q <= RST_CTRL;
         pin_irq_ctrl_reg_q <= RST_CTRL;
      end else if (clk_en && first) begin
         if (w == OP_WR1) begin
            irq_ctrl_reg_one_q <= acc; // [RQ16]
         end
         if (w == OP_WR2) begin
            irq_ctrl_reg_two_q <= acc; // [RQ17]
         end
         if (w == OP_WRP) begin
            pin_irq_ctrl_reg_q <= acc; // [RQ18]
         end
      end
   end

   // Accumulator load requests
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         acc_load_q <= 1'b0;
         acc_data_q <= 4'h0;
      end else if (clk_en) begin
         acc_load_q <= 1'b0;
         if (first && w == OP_RD1) begin
            acc_load_q <= 1'b1;
            acc_data_q <= irq_ctrl_reg_one_q; // [RQ16]
         end else if (first && w == OP_RD2) begin
            acc_load_q <= 1'b1;
            acc_data_q <= irq_ctrl_reg_two_q; // [RQ17]
         end else if (first && w == OP_RDP) begin
            acc_load_q <= 1'b1;
            acc_data_q <= pin_irq_ctrl_reg_q; // [RQ18]
         end
      end
   end

   // Event sources and write-one-to-clear requests
   assign sts_set = {second && !page_ok, ext0_req};
   assign sts_clr = (reg_wr && reg_addr == OFS_STS) ? reg_wdata[ST_W-1:0] : '0;

   // Sticky status; an event in the clearing cycle survives
   generate
      for (genvar i = 0; i < ST_W; i++) begin : g_sts
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               sts_q[i] <= 1'b0;
            end else if (clk_en) begin
               sts_q[i] <= sts_set[i] | (sts_q[i] & ~sts_clr[i]);
            end
         end
      end
   endgenerate

   // Mask register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         msk_q <= RST_MSK;
      end else if (clk_en && reg_wr && reg_addr == OFS_MSK) begin
         msk_q <= reg_wdata[ST_W-1:0];
      end
   end

   // Interrupt level follows the committed status one cycle later
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(sts_q & msk_q);
      end
   end

   // Read port, data valid only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_q <= 8'h00;
      end else if (clk_en) begin
         reg_rdata_q <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               OFS_STS: reg_rdata_q <= {6'h00, sts_q};
               OFS_MSK: reg_rdata_q <= {6'h00, msk_q};
               OFS_VREG: reg_rdata_q <= {irq_ctrl_reg_two_q, irq_ctrl_reg_one_q};
               OFS_CORE: reg_rdata_q <= {1'b0, ext0_request_flag_q, global_irq_enable_flag_q,
                                         skip_q, pin_irq_ctrl_reg_q};
               default: reg_rdata_q <= 8'h00;
            endcase
         end
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   branch_page_a: assert property (first && w[9:7] == OP_BIN
      |=> flow_q.load && !flow_q.push && flow_q.target == {$past(pc_page), $past(w[6:0])}) // [RQ1]
      else $error("in-page branch target wrong");

   long_page_a: assert property (second && long_q == BRI_BL && page_ok
      |=> flow_q.load && flow_q.target[6:0] == $past(w[6:0])
          && flow_q.target[12:7] == $past(long_page[5:0])) // [RQ2]
      else $error("long branch target wrong");

   page_range_a: assert property (second && long_page > 7'(PAGE_MAX)
      |=> !flow_q.load ##0 sts_q[ST_PAGE]) // [RQ3]
      else $error("out of range page transferred");

   ind_call_a: assert property (second && long_q == BRI_BMLA && page_ok
      |=> flow_q.push && flow_q.target[6:0] == $past({d_reg_low_bits, acc})) // [RQ7]
      else $error("indirect call target wrong");

   call2_a: assert property (first && w[9:7] == OP_CALL2
      |=> flow_q.push && flow_q.target[12:7] == PAGE_CALL2) // [RQ5]
      else $error("short call not in page 2");

   rti_restore_a: assert property (first && w == OP_RTI
      |=> flow_q.pop && flow_q.restore && !skip_q) // [RQ8]
      else $error("interrupt return incomplete");

   rts_skip_a: assert property (first && w == OP_RTS
      |=> flow_q.pop && skip_q ##1 (skip_q != $past(take))) // [RQ9]
      else $error("skipping return did not skip once");

   ien_ctl_a: assert property (first && (w == OP_DIS || w == OP_ENA)
      |=> global_irq_enable_flag_q == $past(w[0])) // [RQ10] [RQ11]
      else $error("global enable not updated");

   flag_test_a: assert property (first && w == OP_SKF && !ext0_req
      |=> skip_q == $past(ext0_request_flag_q && !irq_ctrl_reg_one_q[V1_TEST_DIS])
          && ext0_request_flag_q == ($past(ext0_request_flag_q) && !skip_q)) // [RQ12] [RQ13]
      else $error("flag test misbehaved");

   pin_test_a: assert property (first && w == OP_SKP
      |=> skip_q == ($past(int_pin) == $past(pin_irq_ctrl_reg_q[I1_POL]))) // [RQ14] [RQ15]
      else $error("pin test skip wrong");

   ctrl_copy_a: assert property (first && w == OP_WR2 ##1 clk_en && instr.valid && w == OP_RD2 && !skip_q
      |=> acc_load_q && acc_data_q == $past(acc, 2)) // [RQ17]
      else $error("control register copy lost");

   skip_void_a: assert property (take && skip_q
      |=> !flow_q.load && !flow_q.pop && !acc_load_q && !skip_q) // [RQ19]
      else $error("skipped word took effect");

   irq_level_a: assert property (clk_en |=> irq_q == |($past(sts_q) & $past(msk_q)))
      else $error("interrupt level wrong");

   long_call_c: cover property (second && long_q == BRI_BML && page_ok);
   flag_skip_c: cover property (skf_hit ##[1:2] (take && skip_q));
   rti_c: cover property (first && w == OP_RTI);
   irq_c: cover property (irq_q);

endmodule

// file: sim/bri_pmem.sv
`timescale 1ns/1ps
module bri_pmem
   import bri_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic fetch_en,
   input wire logic [5:0] fetch_addr,
   output bri_instr_t instr
);
   logic [WORD_W-1:0] mem [0:63];

   // One word per fetch; an idle bus flips so a stale word never looks fresh
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         instr <= '0;
      end else if (fetch_en) begin
         instr <= {1'b1, mem[fetch_addr]};
      end else begin
         instr <= {1'b0, ~instr.word};
      end
   end
endmodule

// file: sim/branch_return_interrupt_ops_tb.sv
`timescale 1ns/1ps
module branch_return_interrupt_ops_tb;
   import bri_pkg::*;
   typedef struct {logic [9:0] w1; logic [9:0] w2; logic two; logic [3:0] a; logic [2:0] d; logic [3:0] fl;
      logic [12:0] tgt;} bri_row_t;
   logic core_clk = 1'b0;
   logic nrst, fetch_en, int_pin, ext0_req, reg_wr, reg_rd, skip, acc_ld, ien, exf, irq, s0;
   logic [5:0] fetch_addr;
   logic [3:0] acc, acc_dat, v1, v2, i1;
   logic [2:0] d_low;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, rdata, rd_v;
   bri_instr_t instr;
   bri_flow_t flow;
   int fails = 0;
   int samples_checked = 0;
   int k = 0;
   // Ordinary flow cases: words, operands, {load,push,pop,restore}, target
   bri_row_t rows [9] = '{
      '{10'h1AA, 10'h000, 1'b0, 4'h0, 3'h0, 4'h8, {6'h05, 7'h2A}},
      '{10'h0E5, 10'h291, 1'b1, 4'h0, 3'h0, 4'h8, {6'h25, 7'h11}},
      '{10'h0FF, 10'h2FF, 1'b1, 4'h0, 3'h0, 4'h8, {6'h3F, 7'h7F}},
      '{10'h010, 10'h242, 1'b1, 4'hB, 3'h5, 4'h8, {6'h12, 7'h5B}},
      '{10'h133, 10'h000, 1'b0, 4'h0, 3'h0, 4'hC, {6'h02, 7'h33}},
      '{10'h0C5, 10'h240, 1'b1, 4'h0, 3'h0, 4'hC, {6'h05, 7'h40}},
      '{10'h030, 10'h2C0, 1'b1, 4'h7, 3'h2, 4'hC, {6'h30, 7'h27}},
      '{10'h046, 10'h000, 1'b0, 4'h0, 3'h0, 4'h3, 13'h0000},
      '{10'h044, 10'h000, 1'b0, 4'h0, 3'h0, 4'h2, 13'h0000}
   };
   logic [9:0] wops [3] = '{OP_WR1, OP_WR2, OP_WRP};
   logic [9:0] rops [3] = '{OP_RD1, OP_RD2, OP_RDP};
   logic [3:0] vals [3] = '{4'h8, 4'h6, 4'h4};

   always #12.5 core_clk = ~core_clk;

   bri_pmem pmem_u (.core_clk(core_clk), .nrst(nrst), .fetch_en(fetch_en), .fetch_addr(fetch_addr), .instr(instr));

   bri_exec dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .instr(instr), .pc_page(6'h05), .acc(acc),
      .d_reg_low_bits(d_low), .int_pin(int_pin), .ext0_req(ext0_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .flow_q(flow), .skip_q(skip), .acc_load_q(acc_ld), .acc_data_q(acc_dat),
      .global_irq_enable_flag_q(ien), .ext0_request_flag_q(exf), .irq_ctrl_reg_one_q(v1),
      .irq_ctrl_reg_two_q(v2), .pin_irq_ctrl_reg_q(i1), .reg_rdata_q(rdata), .irq_q(irq));

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Fetch strobe stays up between words so back-to-back words never glitch
   task automatic issue(input logic [9:0] w);
      pmem_u.mem[k] = w;
      fetch_addr <= 6'(k);
      fetch_en <= 1'b1;
      k = (k + 1) % 64;
      @(posedge core_clk);
   endtask

   // Last word taken at the next edge; its results are sampled just after
   task automatic settle();
      fetch_en <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   task automatic run(input logic [9:0] w);
      issue(w);
      settle();
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [1:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rd_v = rdata;
   endtask

   task automatic pulse_ext();
      ext0_req <= 1'b1;
      @(posedge core_clk);
      ext0_req <= 1'b0;
      #1;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      tally_and_finish();
   end

   initial begin
      {nrst, fetch_en, int_pin, ext0_req, reg_wr, reg_rd} = 6'h00;
      {fetch_addr, acc, d_low, reg_addr, reg_wdata} = 23'h000000;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      chk(16'({flow.load, flow.push, flow.pop, flow.restore, skip, ien, exf, irq}), 16'h0000);
      chk(16'({v1, v2, i1}), 16'({RST_CTRL, RST_CTRL, RST_CTRL}));
      foreach (rows[i]) begin
         acc <= rows[i].a;
         d_low <= rows[i].d;
         issue(rows[i].w1);
         if (rows[i].two) begin
            issue(rows[i].w2);
         end
         settle();
         chk(16'({flow.load, flow.push, flow.pop, flow.restore}), 16'(rows[i].fl));
         if (rows[i].fl[3]) begin
            chk(16'(flow.target), 16'(rows[i].tgt));
         end
         chk(16'(skip), 16'h0000);
      end
      // Skipping return voids the enable word that follows it
      run(OP_RTS);
      chk(16'({flow.pop, skip}), 16'h0003);
      run(OP_ENA);
      chk(16'({ien, skip}), 16'h0000);
      run(OP_ENA);
      chk(16'(ien), 16'h0001);
      run(OP_DIS);
      chk(16'(ien), 16'h0000);
      for (int i = 0; i < 3; i++) begin
         acc <= vals[i];
         run(wops[i]);
      end
      chk(16'({v1, v2, i1}), 16'h0864);
      rd(OFS_VREG);
      chk(16'(rd_v), 16'h0068);
      acc <= 4'h0;
      for (int i = 0; i < 3; i++) begin
         run(rops[i]);
         chk(16'({acc_ld, acc_dat}), 16'({1'b1, vals[i]}));
      end
      // Flag test enabled: set flag skips and clears, clear flag runs on; test disabled: set flag runs on and stays set
      pulse_ext();
      run(OP_SKF);
      chk(16'({skip, exf}), 16'h0002);
      run(10'h000);
      run(OP_SKF);
      chk(16'(skip), 16'h0000);
      acc <= 4'h1;
      run(OP_WR1);
      pulse_ext();
      run(OP_SKF);
      chk(16'({skip, exf}), 16'h0001);
      // Pin test for both polarities and both levels
      for (int p = 0; p < 4; p++) begin
         int_pin <= p[0];
         if (p == 2) begin
            acc <= 4'h0;
            run(OP_WRP);
         end
         run(OP_SKP);
         chk(16'(skip), 16'(p[0] ^ p[1]));
         run(10'h000);
      end
      // Page above the limit is refused and flagged
      issue(10'h0E0);
      issue(10'h305);
      settle();
      chk(16'({flow.load, flow.push}), 16'h0000);
      rd(OFS_STS);
      chk(16'(rd_v[1:0]), 16'h0003);
      wr(OFS_MSK, 8'h00);
      repeat (2) @(posedge core_clk);
      #1;
      s0 = irq;
      wr(OFS_MSK, 8'h03);
      repeat (2) @(posedge core_clk);
      #1;
      chk(16'({s0, irq}), 16'h0001);
      wr(OFS_STS, 8'h03);
      repeat (2) @(posedge core_clk);
      rd(OFS_STS);
      chk(16'({rd_v[1:0], irq}), 16'h0000);
      // Write then read back to back, with no idle word between
      run(OP_ENA);
      acc <= 4'h9;
      issue(OP_WR2);
      issue(OP_RD2);
      settle();
      chk(16'({acc_ld, acc_dat}), 16'h0019);
      // Core view: request flag still set, enable on, no skip, pin control zero
      rd(OFS_CORE);
      chk(16'(rd_v), 16'h0060);
      // Mid-run reset must drop the enable and the second control register
      nrst <= 1'b0;
      @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      chk(16'({ien, v2, flow.load, skip, irq}), 16'h0000);
      run(OP_ENA);
      chk(16'(ien), 16'h0001);
      tally_and_finish();
   end
endmodule
